//--- verilog/usart_spi_regs.svh
// Constants for the serial port in its synchronous serial-bus mode.
// Assumes inclusion by bare name from package and design files.
`ifndef USART_SPI_REGS_SVH
`define USART_SPI_REGS_SVH

`define OPMODE_W            4
`define OPMODE_SPI_MASTER   4'hE
`define OPMODE_SPI_SLAVE    4'hF
`define CLKSRC_W            2
`define CLKSRC_DIV          2'h1
`define CLKSRC_EXT          2'h3
`define CHAR_LENGTH_FIELD_W              2
`define CHAR_BITS_BASE      4'h5
`define CHAR_BITS_NINE      4'h9
`define DIV_W               16
`define DIV_MIN             16'h0006
`define DIV_PRESCALE        16'h0008
`define SLAVE_RATIO_MIN     6

`endif

//--- verilog/usart_spi_pkg.sv
// Types shared by the serial-bus mode files.
// Assumes the constants header is on the include path.
`include "usart_spi_regs.svh"

package usart_spi_pkg;
   typedef enum logic [1:0] {
      CLK_MCK,
      CLK_DIV,
      CLK_RSV,
      CLK_EXT
   } clk_src_t;
   typedef enum {
      M_IDLE,
      M_LEAD,
      M_SHIFT,
      M_TRAIL,
      M_GAP
   } mst_state_t;
endpackage : usart_spi_pkg

//--- verilog/usart_spi_baud.sv
// Baud generator: makes a half-bit tick from the master clock.
// Assumes the divisor is held stable while a character is in flight.
`include "usart_spi_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module usart_spi_baud #(
   parameter int DIV_W = `DIV_W
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   // Control
   input  wire logic             run_i,
   input  wire logic             prescale_i,
   input  wire logic [DIV_W-1:0] divisor_i,
   // Ticks
   output logic                  half_o
);
   initial begin
      if (DIV_W < 4) $error("DIV_W too small");
   end

   logic [DIV_W+3:0] period_w;
   logic [DIV_W+2:0] half_w;
   logic [DIV_W+3:0] cnt_r;

   // Whole bit period in master clocks; an odd period loses one clock, both halves being half_w
   assign period_w = prescale_i ? {divisor_i, 4'h0} >> 1 : {4'h0, divisor_i};
   assign half_w   = period_w[DIV_W+3:1];

   // Tick every half_w clocks; an odd remainder of the period is dropped
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !run_i) begin
         cnt_r  <= '0;
         half_o <= 1'b0;
      end else if (cnt_r + 1'b1 >= (half_o ? period_w - {1'b0, half_w} : {1'b0, half_w})) begin
         cnt_r  <= '0;
         half_o <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + 1'b1;
         half_o <= 1'b0;
      end
   end
endmodule : usart_spi_baud

`default_nettype wire

//--- verilog/usart_spi_sync.sv
// Two-stage synchroniser for the serial clock and select inputs in slave mode.
// Assumes a single destination clock.
`timescale 1ns/10ps
`default_nettype none

module usart_spi_sync (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   // Level in and out
   input  wire logic d_i,
   input  wire logic rst_val_i,
   output logic      q_o
);
   logic meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         meta_r <= 1'b1;
         q_o    <= 1'b1;
      end else begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
   logic unused_w;
   assign unused_w = rst_val_i;
endmodule : usart_spi_sync

`default_nettype wire

//--- verilog/usart_spi_mode.sv
// Serial port in synchronous serial-bus mode, master or slave.
// Assumes software drives control pulses one cycle wide and keeps config stable.
`include "usart_spi_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module usart_spi_mode #(
   parameter int DIV_W = `DIV_W
) (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              sys_rst_i,
   // Configuration
   input  wire logic [3:0]        op_mode_i,
   input  wire logic [1:0]        clock_source_select_i,
   input  wire logic              clock_output_enable_i,
   input  wire logic [DIV_W-1:0]  clock_divisor_i,
   input  wire logic [1:0]        char_length_field_i,
   input  wire logic              nine_bit_select_i,
   input  wire logic              cpol_i,
   input  wire logic              cpha_i,
   input  wire logic              receive_wait_bit_i,
   input  wire logic [15:0]       timeout_value_field_i,
   // Control pulses
   input  wire logic              tx_reset_i,
   input  wire logic              rx_reset_i,
   input  wire logic              tx_enable_i,
   input  wire logic              tx_disable_i,
   input  wire logic              rx_enable_i,
   input  wire logic              rx_disable_i,
   input  wire logic              status_clear_command_i,
   input  wire logic              force_select_command_i,
   input  wire logic              select_release_command_i,
   // Holding registers
   input  wire logic              thr_write_i,
   input  wire logic [8:0]        thr_data_i,
   input  wire logic              rhr_read_i,
   output logic [8:0]             rhr_data_o,
   // Status
   output logic                   holding_empty_flag_o,
   output logic                   all_done_flag_o,
   output logic                   receive_ready_flag_o,
   output logic                   overrun_flag_o,
   output logic                   underrun_flag_o,
   output logic                   timeout_flag_o,
   // Serial pins
   output logic                   txd_o,
   input  wire logic              rxd_i,
   output logic                   sck_o,
   output logic                   sck_oe_o,
   input  wire logic              sck_i,
   output logic                   rts_o,
   input  wire logic              cts_i
);
   initial begin
      if (DIV_W < 4 || DIV_W > 16) $error("DIV_W out of range");
   end

   logic is_mst_w, is_slv_w;
   logic [3:0] nbits_w;
   logic half_w, sck_s_w, nss_s_w;
   logic tx_en_r, rx_en_r, thr_full_r, sh_busy_r, sck_r, sck_prev_r;
   logic [8:0] thr_r, tsh_r, rsh_r;
   logic [3:0] bit_r;
   logic force_r, nss_r;
   usart_spi_pkg::mst_state_t mst_r;
   logic lead_edge_w, trail_edge_w, slv_active_w;
   logic mst_load_w, char_done_w, rx_capture_w;

   assign is_mst_w = (op_mode_i == `OPMODE_SPI_MASTER);
   assign is_slv_w = (op_mode_i == `OPMODE_SPI_SLAVE);
   // Nine-bit select overrides the length field
   assign nbits_w  = nine_bit_select_i ? `CHAR_BITS_NINE
                     : `CHAR_BITS_BASE + {2'h0, char_length_field_i};

   // Bit clock for master; divisor and source ignored in slave mode
   usart_spi_baud #(.DIV_W(DIV_W)) u_baud (
      .clk_i      (clk_i),
      .sys_rst_i  (sys_rst_i),
      .run_i      (is_mst_w && mst_r != usart_spi_pkg::M_IDLE),
      .prescale_i (clock_source_select_i == `CLKSRC_DIV),
      .divisor_i  (clock_divisor_i),
      .half_o     (half_w)
   );

   usart_spi_sync u_sync_sck (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .d_i       (sck_i),
      .rst_val_i (1'b1),
      .q_o       (sck_s_w)
   );
   usart_spi_sync u_sync_nss (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .d_i       (cts_i),
      .rst_val_i (1'b1),
      .q_o       (nss_s_w)
   );

   // Edge detection of the active serial clock, normalised by polarity
   logic clk_now_w, clk_rise_w, clk_fall_w;
   assign clk_now_w  = is_slv_w ? (sck_s_w ^ cpol_i) : sck_r;
   assign clk_rise_w = clk_now_w && !sck_prev_r;
   assign clk_fall_w = !clk_now_w && sck_prev_r;
   // Phase 1 samples on the first edge; phase 0 samples on the second
   assign lead_edge_w  = cpha_i ? clk_rise_w : clk_fall_w;
   assign trail_edge_w = cpha_i ? clk_fall_w : clk_rise_w;
   assign slv_active_w = is_slv_w && !nss_s_w;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) sck_prev_r <= 1'b0;
      else           sck_prev_r <= clk_now_w;
   end

   // Enables; reset commands also disable
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || tx_reset_i || tx_disable_i) tx_en_r <= 1'b0;
      else if (tx_enable_i)                        tx_en_r <= 1'b1;
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || rx_reset_i || rx_disable_i) rx_en_r <= 1'b0;
      else if (rx_enable_i)                        rx_en_r <= 1'b1;
   end

   // Master sequencer: lead, shift, trail, gap
   logic [4:0] edge_cnt_r;
   assign mst_load_w = is_mst_w && tx_en_r && thr_full_r && mst_r == usart_spi_pkg::M_IDLE
                       && !(receive_wait_bit_i && receive_ready_flag_o);
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || tx_reset_i || !is_mst_w) begin
         mst_r      <= usart_spi_pkg::M_IDLE;
         edge_cnt_r <= '0;
         sck_r      <= 1'b0;
      end else begin
         case (mst_r)
            usart_spi_pkg::M_IDLE: begin
               edge_cnt_r <= '0;
               if (mst_load_w) mst_r <= usart_spi_pkg::M_LEAD;
            end
            usart_spi_pkg::M_LEAD: begin
               if (half_w) edge_cnt_r <= edge_cnt_r + 5'h01;
               if (half_w && edge_cnt_r == 5'h01) begin
                  mst_r      <= usart_spi_pkg::M_SHIFT;
                  edge_cnt_r <= '0;
               end
            end
            usart_spi_pkg::M_SHIFT: begin
               if (half_w) begin
                  sck_r      <= ~sck_r;
                  edge_cnt_r <= edge_cnt_r + 5'h01;
                  if (edge_cnt_r == {nbits_w, 1'b0} - 5'h01) begin
                     mst_r      <= usart_spi_pkg::M_TRAIL;
                     edge_cnt_r <= '0;
                  end
               end
            end
            usart_spi_pkg::M_TRAIL, usart_spi_pkg::M_GAP: begin
               if (half_w) edge_cnt_r <= edge_cnt_r + 5'h01;
               if (half_w && edge_cnt_r == 5'h01) begin
                  mst_r      <= (mst_r == usart_spi_pkg::M_TRAIL) ? usart_spi_pkg::M_GAP
                                                                  : usart_spi_pkg::M_IDLE;
                  edge_cnt_r <= '0;
               end
            end
            default: mst_r <= usart_spi_pkg::M_IDLE;
         endcase
      end
   end

   // Select line: low around each character, or held by force command
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !is_mst_w)      force_r <= 1'b0;
      else if (force_select_command_i) force_r <= 1'b1;
      else if (select_release_command_i) force_r <= 1'b0;
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) nss_r <= 1'b1;
      else nss_r <= !(force_r || mst_r == usart_spi_pkg::M_LEAD
                      || mst_r == usart_spi_pkg::M_SHIFT
                      || mst_r == usart_spi_pkg::M_TRAIL);
   end

   // Bit counting shared by both roles; the last master edge is seen in trail
   logic bit_lead_w, bit_trail_w;
   assign bit_lead_w  = is_mst_w ? (mst_r != usart_spi_pkg::M_IDLE && lead_edge_w)
                                 : (slv_active_w && lead_edge_w);
   assign bit_trail_w = is_mst_w ? (mst_r != usart_spi_pkg::M_IDLE && trail_edge_w)
                                 : (slv_active_w && trail_edge_w);
   assign char_done_w = bit_lead_w && bit_r == nbits_w - 4'h1;
   assign rx_capture_w = char_done_w && rx_en_r;
   logic slv_load_w;
   assign slv_load_w = is_slv_w && tx_en_r && thr_full_r && !sh_busy_r && slv_active_w;

   // Transmit holding register; writes while full are dropped
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || tx_reset_i) begin
         thr_full_r <= 1'b0;
         thr_r      <= '0;
      end else if (thr_write_i && holding_empty_flag_o) begin
         thr_full_r <= 1'b1;
         thr_r      <= thr_data_i;
      end else if (mst_load_w || slv_load_w) begin
         thr_full_r <= 1'b0;
      end
   end

   // Shifter; most significant bit of the character leads
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || tx_reset_i) begin
         tsh_r     <= '0;
         sh_busy_r <= 1'b0;
         bit_r     <= '0;
      end else begin
         if (mst_load_w || slv_load_w) begin
            tsh_r     <= thr_r << (4'h9 - nbits_w);
            sh_busy_r <= 1'b1;
            bit_r     <= '0;
         end else if (bit_trail_w && bit_r != 4'h0 && sh_busy_r) begin
            tsh_r <= {tsh_r[7:0], 1'b1};
         end
         if (bit_lead_w) bit_r <= char_done_w ? 4'h0 : bit_r + 4'h1;
         if (char_done_w) sh_busy_r <= 1'b0;
         // A frame cut short by select rising drops the half-sent character
         if (is_slv_w && nss_s_w) begin
            bit_r     <= '0;
            sh_busy_r <= 1'b0;
         end
      end
   end

   // Output data; idle and underrun keep the line high
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) txd_o <= 1'b1;
      else           txd_o <= (sh_busy_r && tx_en_r) ? tsh_r[8] : 1'b1;
   end

   // Underrun: slave clocked with nothing to send; set beats clear
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) underrun_flag_o <= 1'b0;
      else if (is_slv_w && tx_en_r && bit_lead_w && !sh_busy_r && bit_r == 4'h0)
         underrun_flag_o <= 1'b1;
      else if (status_clear_command_i) underrun_flag_o <= 1'b0;
   end

   // Receive shifter samples the data-in pin on the sample edge
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || rx_reset_i) rsh_r <= '0;
      else if (bit_lead_w)         rsh_r <= {rsh_r[7:0], rxd_i};
   end

   // Receive holding register, ready and overrun; set wins over clear
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || rx_reset_i) begin
         rhr_data_o           <= '0;
         receive_ready_flag_o <= 1'b0;
      end else if (rx_capture_w) begin
         rhr_data_o           <= {rsh_r[7:0], rxd_i} & ~(9'h1FF << nbits_w);
         receive_ready_flag_o <= 1'b1;
      end else if (rhr_read_i) begin
         receive_ready_flag_o <= 1'b0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || rx_reset_i) overrun_flag_o <= 1'b0;
      else if (rx_capture_w && receive_ready_flag_o && !rhr_read_i)
         overrun_flag_o <= 1'b1;
      else if (status_clear_command_i) overrun_flag_o <= 1'b0;
   end

   // Transmitter flags read low while disabled
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         holding_empty_flag_o <= 1'b0;
         all_done_flag_o      <= 1'b0;
      end else begin
         holding_empty_flag_o <= tx_en_r && !thr_full_r && !(thr_write_i && holding_empty_flag_o);
         all_done_flag_o      <= tx_en_r && !thr_full_r && !sh_busy_r && !(thr_write_i && holding_empty_flag_o)
                                 && (!is_mst_w || mst_r == usart_spi_pkg::M_IDLE);
      end
   end

   // Timeout cannot fire in this mode
   logic unused_w;
   assign unused_w = ^timeout_value_field_i ^ clock_output_enable_i;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) timeout_flag_o <= 1'b0;
      else           timeout_flag_o <= 1'b0;
   end

   // Pin outputs; clock rests at polarity level
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sck_o    <= 1'b0;
         sck_oe_o <= 1'b0;
         rts_o    <= 1'b1;
      end else begin
         sck_o    <= sck_r ^ cpol_i;
         sck_oe_o <= is_mst_w;
         rts_o    <= is_mst_w ? nss_r : 1'b1;
      end
   end
endmodule : usart_spi_mode

`default_nettype wire

//--- sim/usart_spi_mode_asserts.sv
// Concurrent checks on the serial-bus mode port boundary.
// Assumes a divisor of six or more, so one bit spans at least six clocks.
`timescale 1ns/10ps
`default_nettype none

module usart_spi_mode_asserts (
   // Clock and reset
   input wire logic       clk_i,
   input wire logic       sys_rst_i,
   // Inputs watched
   input wire logic [3:0] op_mode_i,
   input wire logic       tx_enable_i,
   input wire logic       tx_disable_i,
   input wire logic       status_clear_command_i,
   input wire logic       force_select_command_i,
   input wire logic       select_release_command_i,
   input wire logic       thr_write_i,
   input wire logic       cts_i,
   // Outputs watched
   input wire logic       holding_empty_flag_o,
   input wire logic       all_done_flag_o,
   input wire logic       receive_ready_flag_o,
   input wire logic       overrun_flag_o,
   input wire logic       underrun_flag_o,
   input wire logic       timeout_flag_o,
   input wire logic       txd_o,
   input wire logic       sck_o,
   input wire logic       sck_oe_o,
   input wire logic       rts_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   // Receive clock runs only within transfers, so no timeout
   no_timeout_a: assert property (!timeout_flag_o)
      else $error("timeout flag raised");
   // Clock pin driven only as master, after the mode has settled
   clk_drive_a: assert property ($stable(op_mode_i)[*3] |-> sck_oe_o == (op_mode_i == 4'hE))
      else $error("clock enable does not follow mode");
   tx_off_a: assert property (tx_disable_i ##1 !tx_enable_i[*3] |->
      !holding_empty_flag_o && !all_done_flag_o) else $error("flags high while disabled");
   thr_take_a: assert property (thr_write_i && holding_empty_flag_o |=> !holding_empty_flag_o)
      else $error("accepted write left holding empty");
   // Select leads the first clock edge by one and a half bits
   sel_lead_a: assert property ($fell(rts_o) |-> $stable(sck_o)[*4])
      else $error("clock moved too soon after select");
   sel_gap_a: assert property ($rose(rts_o) |-> rts_o[*5])
      else $error("select gap too short");
   sel_trail_a: assert property ($changed(sck_o) && !rts_o |-> !rts_o[*4])
      else $error("select released too soon after clock");
   force_sel_a: assert property (op_mode_i == 4'hE && force_select_command_i |-> ##[1:3] !rts_o)
      else $error("forced select not low");
   release_sel_a: assert property (op_mode_i == 4'hE && select_release_command_i &&
      all_done_flag_o |-> ##[1:3] rts_o) else $error("select not released");
   ovr_cause_a: assert property ($rose(overrun_flag_o) |-> $past(receive_ready_flag_o))
      else $error("overrun without pending character");
   unr_cause_a: assert property ($rose(underrun_flag_o) |-> op_mode_i == 4'hF && txd_o)
      else $error("underrun outside slave or line low");
   // Only checked while idle, since a set in the same cycle wins
   stat_clear_a: assert property (status_clear_command_i && rts_o && cts_i |=>
      !overrun_flag_o && !underrun_flag_o) else $error("error flags not cleared");

   c_master: cover property (thr_write_i && holding_empty_flag_o && op_mode_i == 4'hE);
   c_ovr: cover property ($rose(overrun_flag_o));
   c_unr: cover property ($rose(underrun_flag_o));
   c_force: cover property (force_select_command_i && op_mode_i == 4'hE);
endmodule : usart_spi_mode_asserts

`default_nettype wire

//--- sim/spi_far_model.sv
// Behavioural far-side device: slave when the port is master, master otherwise.
// Assumes its clock and select changes land away from the system clock edge.
`timescale 1ns/10ps
`default_nettype none

module spi_far_model (
   // Role and format
   input  wire logic       as_master_i,
   input  wire logic       cpol_i,
   input  wire logic       cpha_i,
   input  wire logic [3:0] nbits_i,
   input  wire logic [8:0] tx_word_i,
   // Port side pins
   input  wire logic       dut_txd_i,
   input  wire logic       dut_sck_i,
   input  wire logic       dut_sel_n_i,
   // Far side pins and capture
   output logic            line_o,
   output logic            sck_o,
   output logic            sel_n_o,
   output logic [8:0]      rx_word_o
);
   int idx;
   wire logic ck = as_master_i ? sck_o : dut_sck_i;
   wire logic sel_n = as_master_i ? sel_n_o : dut_sel_n_i;

   initial begin
      sck_o = 1'b0;
      sel_n_o = 1'b1;
      line_o = 1'b0;
      rx_word_o = 9'h000;
      idx = 0;
   end

   // A level is enough; the first bit is presented as soon as select falls
   always @(negedge sel_n) begin
      idx = 0;
      rx_word_o = 9'h000;
      line_o = tx_word_i[nbits_i-1];
   end
   // Released line shows no stale value
   always @(posedge sel_n) line_o = ~line_o;

   // Same edge pairing as the port, most significant bit first
   always @(ck) begin
      if (!sel_n) begin
         if ((ck != cpol_i) == cpha_i) begin
            rx_word_o = {rx_word_o[7:0], dut_txd_i};
            idx++;
         end else if (idx < nbits_i) begin
            line_o = tx_word_i[nbits_i-1-idx];
         end
      end
   end

   // One frame clocked by the far side; clock stands still between frames
   task automatic send(input int half);
      #3;
      sck_o = cpol_i;
      #(half) sel_n_o = 1'b0;
      #(2*half);
      repeat (2*nbits_i) begin
         #(half) sck_o = ~sck_o;
      end
      #(2*half) sel_n_o = 1'b1;
      #(2*half);
   endtask : send
endmodule : spi_far_model

`default_nettype wire

//--- sim/usart_spi_mode_tb.sv
// Self-checking bench for the serial-bus mode port, as master and as slave.
// Assumes the far-side model and the checker module are compiled beforehand.
`timescale 1ns/10ps
`default_nettype none

module usart_spi_mode_tb;
   logic        clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic [3:0]  op_mode = 4'hE;
   logic [3:0]  nb = 4'h8;
   logic [1:0]  clk_src = 2'h0;
   logic [1:0]  char_length_field = 2'h3;
   logic [15:0] div = 16'h0006;
   logic [8:0]  thr_d = 9'h000;
   logic [8:0]  far_word = 9'h000;
   logic        nine = 1'b0, cpol = 1'b0, cpha = 1'b1, rwait = 1'b0, far_master = 1'b0;
   logic        tx_rst = 1'b0, rx_rst = 1'b0, tx_en = 1'b0, tx_dis = 1'b0, rx_en = 1'b0;
   logic        sclr = 1'b0, fsel = 1'b0, rsel = 1'b0, thr_wr = 1'b0, rhr_rd = 1'b0;
   logic [8:0]  rhr_q, far_rx;
   logic        he, ad, rr, ov, ur, tmo, txd, sck, oe, rts, rxd, far_sck, far_sel_n;
   int          n_mismatch = 0;
   int          n_compared = 0;

   always #5 clk_i = ~clk_i;

   usart_spi_mode DUT (.clk_i, .sys_rst_i, .op_mode_i(op_mode), .clock_source_select_i(clk_src),
      .clock_output_enable_i(1'b1), .clock_divisor_i(div), .char_length_field_i(char_length_field),
      .nine_bit_select_i(nine), .cpol_i(cpol), .cpha_i(cpha), .receive_wait_bit_i(rwait),
      .timeout_value_field_i(16'hFFFF), .tx_reset_i(tx_rst), .rx_reset_i(rx_rst),
      .tx_enable_i(tx_en), .tx_disable_i(tx_dis), .rx_enable_i(rx_en), .rx_disable_i(1'b0),
      .status_clear_command_i(sclr), .force_select_command_i(fsel),
      .select_release_command_i(rsel), .thr_write_i(thr_wr), .thr_data_i(thr_d),
      .rhr_read_i(rhr_rd), .rhr_data_o(rhr_q), .holding_empty_flag_o(he), .all_done_flag_o(ad),
      .receive_ready_flag_o(rr), .overrun_flag_o(ov), .underrun_flag_o(ur), .timeout_flag_o(tmo),
      .txd_o(txd), .rxd_i(rxd), .sck_o(sck), .sck_oe_o(oe), .sck_i(far_sck), .rts_o(rts),
      .cts_i(far_sel_n));

   spi_far_model u_far (.as_master_i(far_master), .cpol_i(cpol), .cpha_i(cpha), .nbits_i(nb),
      .tx_word_i(far_word), .dut_txd_i(txd), .dut_sck_i(sck), .dut_sel_n_i(rts), .line_o(rxd),
      .sck_o(far_sck), .sel_n_o(far_sel_n), .rx_word_o(far_rx));

   task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // Called at a falling edge; returns one cycle later with the strobe low
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk_i);
      s = 1'b0;
   endtask : pulse

   // Bus mode m maps to polarity m[1] and phase of inverted m[0]
   task automatic cfg(input logic [3:0] m, input logic [1:0] md, input logic n9,
                      input logic [1:0] len);
      op_mode = m;
      cpol = md[1];
      cpha = ~md[0];
      nine = n9;
      char_length_field = len;
      nb = n9 ? 4'h9 : 4'h5 + {2'h0, len};
      far_master = (m == 4'hF);
      @(negedge clk_i);
      pulse(tx_rst);
      pulse(rx_rst);
      pulse(tx_en);
      pulse(rx_en);
   endtask : cfg

   task automatic wait_done();
      int i;
      repeat (3) @(negedge clk_i);
      for (i = 0; i < 600 && all_done_ok() == 0; i++) @(negedge clk_i);
      chk({8'h00, ad}, 9'h001, "all done");
   endtask : wait_done

   function automatic bit all_done_ok();
      return ad === 1'b1;
   endfunction : all_done_ok

   task automatic mchar(input logic [8:0] d, input logic [8:0] f);
      logic [8:0] mask;
      mask = 9'h1FF >> (4'h9 - nb);
      far_word = f;
      thr_d = d;
      pulse(thr_wr);
      wait_done();
      chk(far_rx, d & mask, "far side received");
      chk(rhr_q, f & mask, "receive holding");
   endtask : mchar

   task automatic t_master();
      for (int m = 0; m < 4; m++) begin
         cfg(4'hE, m[1:0], 1'b0, 2'h3);
         mchar(9'h0A5 ^ m[8:0], 9'h03C + m[8:0]);
         chk({8'h00, rr}, 9'h001, "receive ready");
         pulse(rhr_rd);
      end
      cfg(4'hE, 2'h1, 1'b1, 2'h0);
      mchar(9'h1A5, 9'h15A);
      pulse(rhr_rd);
      cfg(4'hE, 2'h2, 1'b0, 2'h0);
      mchar(9'h1F5, 9'h00A);
      $display("test master modes and lengths done");
   endtask : t_master

   task automatic t_overrun();
      cfg(4'hE, 2'h0, 1'b0, 2'h3);
      mchar(9'h011, 9'h022);
      chk({8'h00, ov}, 9'h000, "no overrun yet");
      mchar(9'h033, 9'h044);
      chk({8'h00, ov}, 9'h001, "overrun");
      pulse(sclr);
      chk({8'h00, ov}, 9'h000, "overrun cleared");
      rwait = 1'b1;
      thr_d = 9'h055;
      pulse(thr_wr);
      repeat (40) @(negedge clk_i);
      chk({8'h00, rts}, 9'h001, "held by receive wait");
      pulse(rhr_rd);
      wait_done();
      chk(far_rx, 9'h055, "sent after read");
      rwait = 1'b0;
      $display("test overrun and receive wait done");
   endtask : t_overrun

   task automatic t_force();
      cfg(4'hE, 2'h3, 1'b0, 2'h3);
      pulse(fsel);
      repeat (3) @(negedge clk_i);
      chk({8'h00, rts}, 9'h000, "select forced");
      mchar(9'h0C6, 9'h039);
      repeat (12) @(negedge clk_i);
      chk({8'h00, rts}, 9'h000, "select still forced");
      pulse(rsel);
      repeat (3) @(negedge clk_i);
      chk({8'h00, rts}, 9'h001, "select released");
      $display("test forced select done");
   endtask : t_force

   task automatic t_txoff();
      cfg(4'hE, 2'h0, 1'b0, 2'h3);
      chk({7'h00, he, ad}, 9'h003, "idle enabled");
      pulse(tx_dis);
      repeat (2) @(negedge clk_i);
      chk({7'h00, he, ad}, 9'h000, "flags while disabled");
      thr_d = 9'h0FF;
      pulse(thr_wr);
      pulse(tx_en);
      repeat (30) @(negedge clk_i);
      chk({6'h00, he, ad, rts}, 9'h007, "lost write not sent");
      $display("test transmitter disabled done");
   endtask : t_txoff

   // Divisor and source are set to values that would break a master
   task automatic t_slave();
      clk_src = 2'h3;
      div = 16'h0001;
      for (int m = 0; m < 4; m++) begin
         cfg(4'hF, m[1:0], 1'b0, 2'h3);
         far_word = 9'h0C3 ^ m[8:0];
         thr_d = 9'h05A + m[8:0];
         pulse(thr_wr);
         u_far.send(50);
         @(negedge clk_i);
         chk(far_rx, thr_d, "slave sent");
         chk(rhr_q, far_word, "slave received");
         pulse(rhr_rd);
      end
      u_far.send(50);
      @(negedge clk_i);
      chk({8'h00, ur}, 9'h001, "underrun");
      chk(far_rx, 9'h0FF, "line high on underrun");
      pulse(sclr);
      chk({7'h00, ur, tmo}, 9'h000, "underrun cleared");
      clk_src = 2'h0;
      div = 16'h0006;
      $display("test slave modes done");
   endtask : t_slave

   task automatic end_of_test();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test

   initial begin
      repeat (20) @(negedge clk_i);
      sys_rst_i = 1'b0;
      @(negedge clk_i);
      chk({5'h00, he, ad, txd, rts}, 9'h003, "reset state");
      t_master();
      t_overrun();
      t_force();
      t_txoff();
      t_slave();
      end_of_test();
   end

   // Run should take about 15 us; allow over six times that
   initial begin
      #100000;
      n_mismatch++;
      $display("MISMATCH %0t watchdog expired", $time);
      end_of_test();
   end
endmodule : usart_spi_mode_tb

bind usart_spi_mode usart_spi_mode_asserts u_chk (.clk_i, .sys_rst_i, .op_mode_i, .tx_enable_i,
   .tx_disable_i, .status_clear_command_i, .force_select_command_i, .select_release_command_i,
   .thr_write_i, .cts_i, .holding_empty_flag_o, .all_done_flag_o, .receive_ready_flag_o,
   .overrun_flag_o, .underrun_flag_o, .timeout_flag_o, .txd_o, .sck_o, .sck_oe_o, .rts_o);

`default_nettype wire
